// ===== hdl/rfc_config_regs.sv
`timescale 1ns/1ps
`include "rfc_defines.svh"

module rfc_config_regs (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic [1:0] address_filter_policy,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr,
   output logic rx_addr_accept,
   output logic [7:0] own_packet_address,
   output logic [7:0] channel_index,
   output logic [4:0] rx_intermediate_base_word_a,
   output logic signed [7:0] synth_base_word_a_offset,
   output logic [23:0] base_word_a,
   output logic [1:0] filter_bw_exponent,
   output logic [1:0] filter_bw_mantissa,
   output logic [3:0] symbol_rate_exponent,
   output logic [8:0] symbol_rate_mantissa
);

   // one register and one next value per group
   logic [7:0] own_addr_reg;
   logic [7:0] own_addr_next;
   logic [7:0] channel_reg;
   logic [7:0] channel_next;
   logic [`RFC_IF_CTRL_W-1:0] if_ctrl_reg;
   logic [`RFC_IF_CTRL_W-1:0] if_ctrl_next;
   logic [7:0] ofs_ctrl_reg;
   logic [7:0] ofs_ctrl_next;
   logic [`RFC_BASE_WORD_A_HIGH_W-1:0] base_word_a_high_reg;
   logic [`RFC_BASE_WORD_A_HIGH_W-1:0] base_word_a_high_next;
   logic [7:0] base_word_a_mid_reg;
   logic [7:0] base_word_a_mid_next;
   logic [7:0] base_word_a_low_reg;
   logic [7:0] base_word_a_low_next;
   logic [7:0] mdm_bw_reg;
   logic [7:0] mdm_bw_next;
   logic [7:0] mdm_rate_reg;
   logic [7:0] mdm_rate_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic hit_reg;
   logic hit_next;
   logic accept_reg;
   logic accept_next;

   function automatic logic addr_match(input logic [1:0] pol, input logic [7:0] a,
                                       input logic [7:0] own);
      rfc_pkg::rfc_adr_policy_e p;
      p = rfc_pkg::rfc_adr_policy_e'(pol);
      unique case (p)
         rfc_pkg::RFC_ADR_NONE: addr_match = 1'b1;
         rfc_pkg::RFC_ADR_NO_BCAST: addr_match = (a == own);
         rfc_pkg::RFC_ADR_BCAST_ZERO: addr_match = (a == own) || (a == `RFC_ADDR_BCAST_LOW);
         rfc_pkg::RFC_ADR_BCAST_BOTH: addr_match = (a == own) ||
            (a == `RFC_ADDR_BCAST_LOW) || (a == `RFC_ADDR_BCAST_HIGH);
      endcase
   endfunction : addr_match

   // write strobe for one register offset
   function automatic logic wr_sel(input logic wr, input logic [5:0] addr,
                                   input logic [5:0] ofs);
      wr_sel = wr && (addr == ofs);
   endfunction : wr_sel

   // narrow registers keep their stored bits only
   function automatic logic [`RFC_NARROW_W-1:0] keep_low6(input logic [7:0] v);
      keep_low6 = v[`RFC_NARROW_W-1:0];
   endfunction : keep_low6

   // unstored top bits read back as zero
   function automatic logic [7:0] pad_low6(input logic [`RFC_NARROW_W-1:0] v);
      pad_low6 = {`RFC_RSVD_PAD, v};
   endfunction : pad_low6

   // own packet address
   always_comb begin
      own_addr_next = own_addr_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_OWN_ADDR)) begin
         own_addr_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         own_addr_reg <= `RFC_RST_OWN_ADDR;
      end else begin
         own_addr_reg <= own_addr_next;
      end
   end

   // channel number
   always_comb begin
      channel_next = channel_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_CHANNEL)) begin
         channel_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         channel_reg <= `RFC_RST_CHANNEL;
      end else begin
         channel_reg <= channel_next;
      end
   end

   // receive if control
   // bit 5 is a stored reserved bit, read back
   always_comb begin
      if_ctrl_next = if_ctrl_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_IF_CTRL)) begin
         if_ctrl_next = keep_low6(reg_wdata);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         if_ctrl_reg <= `RFC_RST_IF_CTRL;
      end else begin
         if_ctrl_reg <= if_ctrl_next;
      end
   end

   // synthesiser frequency offset
   always_comb begin
      ofs_ctrl_next = ofs_ctrl_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_OFS_CTRL)) begin
         ofs_ctrl_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ofs_ctrl_reg <= `RFC_RST_OFS_CTRL;
      end else begin
         ofs_ctrl_reg <= ofs_ctrl_next;
      end
   end

   // frequency word high byte
   // bits 7:6 dropped on write, read as zero
   always_comb begin
      base_word_a_high_next = base_word_a_high_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_BASE_WORD_A_HIGH)) begin
         base_word_a_high_next = keep_low6(reg_wdata);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         base_word_a_high_reg <= `RFC_RST_BASE_WORD_A_HIGH;
      end else begin
         base_word_a_high_reg <= base_word_a_high_next;
      end
   end

   // frequency word middle byte
   always_comb begin
      base_word_a_mid_next = base_word_a_mid_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_BASE_WORD_A_MID)) begin
         base_word_a_mid_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         base_word_a_mid_reg <= `RFC_RST_BASE_WORD_A_MID;
      end else begin
         base_word_a_mid_reg <= base_word_a_mid_next;
      end
   end

   // frequency word low byte
   always_comb begin
      base_word_a_low_next = base_word_a_low_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_BASE_WORD_A_LOW)) begin
         base_word_a_low_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         base_word_a_low_reg <= `RFC_RST_BASE_WORD_A_LOW;
      end else begin
         base_word_a_low_reg <= base_word_a_low_next;
      end
   end

   // filter bandwidth and symbol-rate exponent
   always_comb begin
      mdm_bw_next = mdm_bw_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_MDM_BW)) begin
         mdm_bw_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mdm_bw_reg <= `RFC_RST_MDM_BW;
      end else begin
         mdm_bw_reg <= mdm_bw_next;
      end
   end

   // symbol-rate mantissa, hidden bit added at the port
   always_comb begin
      mdm_rate_next = mdm_rate_reg;
      if (wr_sel(reg_wr, reg_addr, `RFC_OFF_MDM_RATE)) begin
         mdm_rate_next = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mdm_rate_reg <= `RFC_RST_MDM_RATE;
      end else begin
         mdm_rate_reg <= mdm_rate_next;
      end
   end

   // read port: data holds until the next read
   // a read beside a write returns the old value
   always_comb begin
      rdata_next = rdata_reg;
      hit_next = 1'b0;
      if (reg_rd) begin
         hit_next = 1'b1;
         unique case (reg_addr)
            `RFC_OFF_OWN_ADDR: rdata_next = own_addr_reg;
            `RFC_OFF_CHANNEL: rdata_next = channel_reg;
            `RFC_OFF_IF_CTRL: rdata_next = pad_low6(if_ctrl_reg);
            `RFC_OFF_OFS_CTRL: rdata_next = ofs_ctrl_reg;
            `RFC_OFF_BASE_WORD_A_HIGH: rdata_next = pad_low6(base_word_a_high_reg);
            `RFC_OFF_BASE_WORD_A_MID: rdata_next = base_word_a_mid_reg;
            `RFC_OFF_BASE_WORD_A_LOW: rdata_next = base_word_a_low_reg;
            `RFC_OFF_MDM_BW: rdata_next = mdm_bw_reg;
            `RFC_OFF_MDM_RATE: rdata_next = mdm_rate_reg;
            default: begin
               rdata_next = `RFC_RDATA_UNMAPPED;
               hit_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= `RFC_RST_RDATA;
         hit_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         hit_reg <= hit_next;
      end
   end

   // registered verdict, one cycle after rx_addr_valid
   always_comb begin
      accept_next = accept_reg;
      if (rx_addr_valid) begin
         accept_next = addr_match(address_filter_policy, rx_addr, own_addr_reg);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         accept_reg <= 1'b0;
      end else begin
         accept_reg <= accept_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_hit = hit_reg;
   assign rx_addr_accept = accept_reg;
   assign own_packet_address = own_addr_reg;
   assign channel_index = channel_reg;
   assign rx_intermediate_base_word_a = if_ctrl_reg[`RFC_IF_MSB:`RFC_IF_LSB];
   assign synth_base_word_a_offset = $signed(ofs_ctrl_reg);
   assign base_word_a = {2'h0, base_word_a_high_reg, base_word_a_mid_reg, base_word_a_low_reg};
   assign filter_bw_exponent = mdm_bw_reg[`RFC_BW_EXP_MSB:`RFC_BW_EXP_LSB];
   assign filter_bw_mantissa = mdm_bw_reg[`RFC_BW_MAN_MSB:`RFC_BW_MAN_LSB];
   assign symbol_rate_exponent = mdm_bw_reg[`RFC_RATE_EXP_MSB:`RFC_RATE_EXP_LSB];
   assign symbol_rate_mantissa = {`RFC_HIDDEN_BIT, mdm_rate_reg};

endmodule : rfc_config_regs

// ===== hdl/rfc_defines.svh
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

`define RFC_OFF_OWN_ADDR 6'h09
`define RFC_OFF_CHANNEL 6'h0a
`define RFC_OFF_IF_CTRL 6'h0b
`define RFC_OFF_OFS_CTRL 6'h0c
`define RFC_OFF_BASE_WORD_A_HIGH 6'h0d
`define RFC_OFF_BASE_WORD_A_MID 6'h0e
`define RFC_OFF_BASE_WORD_A_LOW 6'h0f
`define RFC_OFF_MDM_BW 6'h10
`define RFC_OFF_MDM_RATE 6'h11

`define RFC_RST_OWN_ADDR 8'h00
`define RFC_RST_CHANNEL 8'h00
`define RFC_RST_IF_CTRL 6'h0f
`define RFC_RST_OFS_CTRL 8'h00
`define RFC_RST_BASE_WORD_A_HIGH 6'h1e
`define RFC_RST_BASE_WORD_A_MID 8'hc4
`define RFC_RST_BASE_WORD_A_LOW 8'hec
`define RFC_RST_MDM_BW 8'h8c
`define RFC_RST_MDM_RATE 8'h22

`define RFC_IF_CTRL_W 6
`define RFC_BASE_WORD_A_HIGH_W 6
`define RFC_ADDR_BCAST_LOW 8'h00
`define RFC_ADDR_BCAST_HIGH 8'hff

`define RFC_BW_EXP_MSB 7
`define RFC_BW_EXP_LSB 6
`define RFC_BW_MAN_MSB 5
`define RFC_BW_MAN_LSB 4
`define RFC_RATE_EXP_MSB 3
`define RFC_RATE_EXP_LSB 0
`define RFC_IF_MSB 4
`define RFC_HIDDEN_BIT 1'h1
`define RFC_IF_LSB 0
`define RFC_NARROW_W 6
`define RFC_RSVD_PAD 2'h0
`define RFC_RST_RDATA 8'h00
`define RFC_RDATA_UNMAPPED 8'h00

`endif

// ===== hdl/rfc_pkg.sv
package rfc_pkg;
   typedef enum logic [1:0] {
      RFC_ADR_NONE,
      RFC_ADR_NO_BCAST,
      RFC_ADR_BCAST_ZERO,
      RFC_ADR_BCAST_BOTH
   } rfc_adr_policy_e;
   typedef logic [7:0] rfc_byte_t;
endpackage : rfc_pkg

// ===== sim/rfc_config_regs_checker.sv
`timescale 1ns/1ps
module rfc_config_regs_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [1:0] address_filter_policy,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr,
   input wire logic rx_addr_accept,
   input wire logic [7:0] own_packet_address,
   input wire logic [7:0] channel_index,
   input wire logic [4:0] rx_intermediate_base_word_a,
   input wire logic signed [7:0] synth_base_word_a_offset,
   input wire logic [23:0] base_word_a,
   input wire logic [1:0] filter_bw_exponent,
   input wire logic [1:0] filter_bw_mantissa,
   input wire logic [3:0] symbol_rate_exponent,
   input wire logic [8:0] symbol_rate_mantissa
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   sequence s_chk(p, a);
      rx_addr_valid && address_filter_policy == p && rx_addr == a;
   endsequence
   a_own_write: assert property (s_wr(6'h09) |=> own_packet_address == $past(reg_wdata))
      else $error("own address write lost");
   a_channel_index_write: assert property (s_wr(6'h0a) |=> channel_index == $past(reg_wdata))
      else $error("channel write lost");
   a_ofs_write: assert property (s_wr(6'h0c) |=> synth_base_word_a_offset == $past(reg_wdata))
      else $error("offset write lost");
   a_base_word_a_low: assert property (s_wr(6'h0f) |=> base_word_a[7:0] == $past(reg_wdata))
      else $error("low frequency byte lost");
   a_bw_split: assert property (s_wr(6'h10) |=> {filter_bw_exponent, filter_bw_mantissa,
      symbol_rate_exponent} == $past(reg_wdata))
      else $error("bandwidth fields misplaced");
   a_base_word_a_top: assert property (s_wr(6'h0d) |=> base_word_a[23:22] == 2'h0 &&
      base_word_a[21:16] == $past(reg_wdata[5:0]))
      else $error("frequency word high byte wrong");
   a_rate_hidden: assert property (s_wr(6'h11) |=>
      symbol_rate_mantissa == {1'b1, $past(reg_wdata)})
      else $error("symbol rate mantissa wrong");
   a_if_write: assert property (s_wr(6'h0b) |=>
      rx_intermediate_base_word_a == $past(reg_wdata[4:0]))
      else $error("intermediate frequency write lost");
   a_bcast_zero: assert property (s_chk(2'h2, 8'h00) |=> rx_addr_accept)
      else $error("zero broadcast refused");
   a_no_check: assert property (rx_addr_valid && address_filter_policy == 2'h0 |=>
      rx_addr_accept)
      else $error("unchecked address refused");
   a_no_bcast: assert property (rx_addr_valid && address_filter_policy == 2'h1 &&
      rx_addr != own_packet_address |=> !rx_addr_accept)
      else $error("foreign address accepted");
   a_bcast_ff: assert property (rx_addr_valid && rx_addr == 8'hff &&
      address_filter_policy == 2'h3 |=> rx_addr_accept)
      else $error("broadcast address refused");
endmodule : rfc_config_regs_checker

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rx_addr_valid = 0;
   logic reg_hit, rx_addr_accept;
   logic [5:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, rx_addr = '0, lf = 8'h43, reg_rdata, own_packet_address;
   logic [7:0] channel_index, q[$], w[9];
   logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22};
   logic [1:0] address_filter_policy = '0, filter_bw_exponent, filter_bw_mantissa;
   logic [4:0] rx_intermediate_base_word_a;
   logic signed [7:0] synth_base_word_a_offset;
   logic [23:0] base_word_a;
   logic [3:0] symbol_rate_exponent;
   logic [8:0] symbol_rate_mantissa;
   int error_cnt = 0, n_tests = 0;
   logic aq[$];
   logic acc_due = 0;
   rfc_config_regs dut (.*);
   initial forever #5 clk_sys = ~clk_sys;
   task chk(input logic [23:0] s, input logic [23:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task wr(input int a, input logic [7:0] d);
      @(negedge clk_sys) reg_wr = 1;
      reg_addr = 6'(a);
      reg_wdata = d;
      @(negedge clk_sys) reg_wr = 0;
   endtask : wr
   task rd(input int a, input logic [7:0] e);
      @(negedge clk_sys) reg_rd = 1;
      reg_addr = 6'(a);
      if (a inside {[9:17]}) q.push_back(e);
      @(negedge clk_sys) reg_rd = 0;
   endtask : rd
   task ac(input logic [1:0] p, input logic [7:0] a);
      @(negedge clk_sys) rx_addr_valid = 1;
      address_filter_policy = p;
      rx_addr = a;
      aq.push_back(p == 0 || a == w[0] || (p[1] && a == 0) || (p == 3 && a == 8'hff));
      @(negedge clk_sys) rx_addr_valid = 0;
   endtask : ac
   // read results and verdicts land one cycle after the strobe
   always @(posedge clk_sys) begin
      if (reg_hit === 1'b1) chk(reg_rdata, q.pop_front());
      if (acc_due) chk(rx_addr_accept, aq.pop_front());
      acc_due <= rx_addr_valid && nrst;
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      nrst = 1;
      for (int i = 9; i < 18; i++) rd(i, rv[i-9]);
      for (int i = 9; i < 18; i++) begin
         lf = lfsr_next(lf);
         w[i-9] = lf;
         wr(i, lf);
      end
      wr(8, 8'hff);
      for (int i = 9; i < 18; i++) rd(i, w[i-9] & ((i == 11 || i == 13) ? 8'h3f : 8'hff));
      rd(18, 8'h00);
      chk(reg_rdata, 0);
      chk(reg_hit, 0);
      chk(base_word_a, {2'h0, w[4][5:0], w[5], w[6]});
      chk(symbol_rate_mantissa, {1'b1, w[8]});
      chk({filter_bw_exponent, filter_bw_mantissa, symbol_rate_exponent}, w[7]);
      chk(rx_intermediate_base_word_a, w[2][4:0]);
      chk($unsigned(synth_base_word_a_offset), w[3]);
      chk(channel_index, w[1]);
      chk(own_packet_address, w[0]);
      for (int p = 0; p < 4; p++) begin
         ac(2'(p), w[0]);
         ac(2'(p), 8'h00);
         ac(2'(p), 8'hff);
         ac(2'(p), w[0] ^ 8'h01);
      end
      @(negedge clk_sys) nrst = 0;
      @(negedge clk_sys) nrst = 1;
      rd(10, 8'h00);
      rd(13, 8'h1e);
      chk(own_packet_address, 0);
      chk(rx_addr_accept, 0);
      repeat (2) @(negedge clk_sys);
      chk(24'(q.size()), 0);
      chk(24'(aq.size()), 0);
      report_and_stop();
   end
   initial begin
      #20us;
      error_cnt++;
      report_and_stop();
   end
endmodule : testbench
bind rfc_config_regs rfc_config_regs_checker chk_i (.*);
